// file: hdl/omc_operating_mode.v
`timescale 1ns/1ps
`include "omc_regs.vh"
module omc_operating_mode #(
  parameter BOOT1_CYC = `OMC_BOOT1_CYC,
  parameter BOOT2_CYC = `OMC_BOOT2_CYC,
  parameter MOT_HIB_CYC = `OMC_MOT_HIB_CYC,
  parameter TICK_CYC = `OMC_AUTO_TICK_CYC
) (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_boot_strap_select,
  input wire i_wake_pin,
  input wire i_motion_detect_pin,
  input wire i_trigger_pin,
  input wire i_wake_event,
  input wire i_meas_done,
  output reg o_meas_start,
  output reg o_sensor_power,
  output reg o_bus_available,
  output reg o_motion_detect_en,
  output reg [2:0] o_mode,
  output reg [7:0] o_rate_setting
);
  // ==========================================
  // States
  localparam [6:0] ST_HIB = 7'h01;
  localparam [6:0] ST_BOOT = 7'h02;
  localparam [6:0] ST_STBY = 7'h04;
  localparam [6:0] ST_WAKE = 7'h08;
  localparam [6:0] ST_SLEEP = 7'h10;
  localparam [6:0] ST_TWAIT = 7'h20;
  localparam [6:0] ST_TMEAS = 7'h40;

  reg [6:0] state_q;
  reg [31:0] ctrl_q;
  reg [31:0] aslp_q;
  reg [31:0] wake_cfg_q;
  reg [31:0] sleep_cfg_q;
  reg [31:0] scratch_q;
  reg [31:0] cnt_q;
  reg [31:0] hold_q;
  reg [31:0] aslp_cnt_q;
  reg [31:0] tick_q;
  reg strap_q;
  reg [31:0] prdata_q;
  reg meas_busy_q;

  wire wake_rise;
  wire wake_fall;
  wire trig_rise;

  omc_edge_det u_wake (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_level(i_wake_pin),
    .o_rise(wake_rise),
    .o_fall(wake_fall)
  );

  omc_edge_det u_trig (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_level(i_trigger_pin),
    .o_rise(trig_rise),
    .o_fall()
  );

  function [2:0] mode_code;
    input [6:0] st;
    begin
      if (st == ST_HIB) begin
        mode_code = 3'h0;
      end else if (st == ST_BOOT) begin
        mode_code = 3'h1;
      end else if (st == ST_STBY) begin
        mode_code = 3'h2;
      end else if (st == ST_WAKE) begin
        mode_code = 3'h3;
      end else if (st == ST_SLEEP) begin
        mode_code = 3'h4;
      end else if (st == ST_TWAIT) begin
        mode_code = 3'h5;
      end else begin
        mode_code = 3'h6;
      end
    end
  endfunction

  // ==========================================
  // APB slave
  wire bus_ok = (state_q != ST_HIB) && (state_q != ST_BOOT);
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite & bus_ok;
  wire [1:0] func = ctrl_q[`OMC_CTRL_FUNC_MSB:`OMC_CTRL_FUNC_LSB];
  wire trig_mode = (func == `OMC_FUNC_TRIG) && !strap_q;
  wire aws_on = (aslp_q[15:0] != 16'h0000);
  wire aws_src = |(ctrl_q[`OMC_CTRL_AWS_MSB:`OMC_CTRL_AWS_LSB]) & i_wake_event;
  wire active_bit = ctrl_q[`OMC_CTRL_ACTIVE_BIT];
  wire boot_done = strap_q ? (cnt_q >= BOOT2_CYC - 1) : (cnt_q >= BOOT1_CYC - 1);
  wire mot_hib = strap_q && (hold_q >= MOT_HIB_CYC - 1) && !i_motion_detect_pin;

  assign o_pready = 1'b1;
  // Access while the bus is unavailable (Hibernate or Boot) reports an error instead of hanging
  assign o_pslverr = acc & ~bus_ok;
  assign o_prdata = prdata_q;

  always @* begin
    prdata_q = 32'h00000000;
    if (!bus_ok) begin
      prdata_q = 32'h00000000;
    end else if (i_paddr == `OMC_CTRL_ADDR) begin
      prdata_q = ctrl_q;
    end else if (i_paddr == `OMC_AUTO_SLEEP_ADDR) begin
      prdata_q = aslp_q;
    end else if (i_paddr == `OMC_WAKE_CFG_ADDR) begin
      prdata_q = wake_cfg_q;
    end else if (i_paddr == `OMC_SLEEP_CFG_ADDR) begin
      prdata_q = sleep_cfg_q;
    end else if (i_paddr == `OMC_SCRATCH_ADDR) begin
      prdata_q = scratch_q;
    end else if (i_paddr == `OMC_STATUS_ADDR) begin
      prdata_q = {28'h0000000, strap_q, mode_code(state_q)};
    end
  end

  // ==========================================
  // Mode sequencer and registers
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_BOOT;
      ctrl_q <= `OMC_CTRL_RST;
      aslp_q <= `OMC_AUTO_SLEEP_RST;
      wake_cfg_q <= `OMC_RATE_CFG_RST;
      sleep_cfg_q <= `OMC_RATE_CFG_RST;
      scratch_q <= 32'h00000000;
      cnt_q <= 32'h00000000;
      hold_q <= 32'h00000000;
      aslp_cnt_q <= 32'h00000000;
      tick_q <= 32'h00000000;
      strap_q <= 1'b0;
      meas_busy_q <= 1'b0;
      o_meas_start <= 1'b0;
    end else begin
      o_meas_start <= 1'b0;
      // Motion pin low time is measured everywhere so Active can drop out
      // Saturates so a pin held low for a very long time cannot wrap and cancel the drop out
      if (i_motion_detect_pin) begin
        hold_q <= 32'h00000000;
      end else if (hold_q < MOT_HIB_CYC - 1) begin
        hold_q <= hold_q + 32'h00000001;
      end
      if (wr) begin
        if (i_paddr == `OMC_CTRL_ADDR) begin
          ctrl_q <= i_pwdata;
        end else if (i_paddr == `OMC_AUTO_SLEEP_ADDR) begin
          aslp_q <= i_pwdata;
        end else if (i_paddr == `OMC_WAKE_CFG_ADDR) begin
          wake_cfg_q <= i_pwdata;
        end else if (i_paddr == `OMC_SLEEP_CFG_ADDR) begin
          sleep_cfg_q <= i_pwdata;
        end else if (i_paddr == `OMC_SCRATCH_ADDR) begin
          scratch_q <= i_pwdata;
        end
      end
      case (state_q)
        ST_HIB: begin
          // Registers already cleared on entry
          if (!strap_q && (wake_rise || wake_fall)) begin
            state_q <= ST_BOOT;
            cnt_q <= 32'h00000000;
          end else if (strap_q && i_motion_detect_pin) begin
            state_q <= ST_BOOT;
            cnt_q <= 32'h00000000;
          end
        end
        ST_BOOT: begin
          cnt_q <= cnt_q + 32'h00000001;
          if (cnt_q == 32'h00000000) begin
            strap_q <= i_boot_strap_select;
          end
          if (cnt_q != 32'h00000000 && boot_done) begin
            if (strap_q) begin
              state_q <= ST_WAKE;
              ctrl_q[`OMC_CTRL_ACTIVE_BIT] <= 1'b1;
            end else begin
              state_q <= ST_STBY;
            end
          end
        end
        ST_STBY: begin
          if (mot_hib || ctrl_q[`OMC_CTRL_HIB_EN_BIT]) begin
            state_q <= ST_HIB;
          end else if (trig_mode) begin
            state_q <= ST_TWAIT;
          end else if (active_bit) begin
            state_q <= ST_WAKE;
            // Entering Active from Standby restarts the sleep timer state
            aslp_cnt_q <= 32'h00000000;
            tick_q <= 32'h00000000;
          end
        end
        ST_WAKE, ST_SLEEP: begin
          if (mot_hib) begin
            ctrl_q[`OMC_CTRL_ACTIVE_BIT] <= 1'b0;
            state_q <= ST_STBY;
          end else if (!active_bit) begin
            state_q <= ST_STBY;
          end else if (aws_on && aws_src) begin
            state_q <= ST_WAKE;
            aslp_cnt_q <= 32'h00000000;
            tick_q <= 32'h00000000;
          end else if (aws_on && state_q == ST_WAKE) begin
            // Count ticks so the 16-bit count spans long inactivity
            if (tick_q >= TICK_CYC - 1) begin
              tick_q <= 32'h00000000;
              aslp_cnt_q <= aslp_cnt_q + 32'h00000001;
              if (aslp_cnt_q + 32'h00000001 >= {16'h0000, aslp_q[15:0]}) begin
                state_q <= ST_SLEEP;
              end
            end else begin
              tick_q <= tick_q + 32'h00000001;
            end
          end
        end
        ST_TWAIT: begin
          // Clearing the pin function field leaves trigger wait
          if (!trig_mode) begin
            state_q <= ST_STBY;
          end else if (trig_rise) begin
            state_q <= ST_TMEAS;
            o_meas_start <= 1'b1;
            meas_busy_q <= 1'b1;
          end
        end
        ST_TMEAS: begin
          // A measurement in flight always finishes before any mode change
          if (i_meas_done && meas_busy_q) begin
            meas_busy_q <= 1'b0;
            state_q <= ST_TWAIT;
          end
        end
        default: begin
          state_q <= ST_BOOT;
        end
      endcase
      // Entering Hibernate drops everything written by the host
      if (state_q == ST_STBY && (mot_hib || ctrl_q[`OMC_CTRL_HIB_EN_BIT])) begin
        ctrl_q <= `OMC_CTRL_RST;
        aslp_q <= `OMC_AUTO_SLEEP_RST;
        wake_cfg_q <= `OMC_RATE_CFG_RST;
        sleep_cfg_q <= `OMC_RATE_CFG_RST;
        scratch_q <= 32'h00000000;
      end
    end
  end

  // ==========================================
  // Registered outputs
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sensor_power <= 1'b0;
      o_bus_available <= 1'b0;
      o_motion_detect_en <= 1'b0;
      o_mode <= 3'h1;
      o_rate_setting <= 8'h00;
    end else begin
      o_mode <= mode_code(state_q);
      o_bus_available <= bus_ok;
      // Sensing in Active (wake and sleep) and while a triggered measurement is running
      o_sensor_power <= (state_q == ST_WAKE) || (state_q == ST_SLEEP) ||
        (state_q == ST_TMEAS);
      o_motion_detect_en <= strap_q && (state_q == ST_WAKE || state_q == ST_SLEEP);
      o_rate_setting <= (state_q == ST_SLEEP) ? sleep_cfg_q[7:0] : wake_cfg_q[7:0];
    end
  end
endmodule

// file: hdl/omc_regs.vh
`ifndef OMC_REGS_VH
`define OMC_REGS_VH
// ==========================================
// Register byte offsets
`define OMC_CTRL_ADDR 12'h000
`define OMC_AUTO_SLEEP_ADDR 12'h004
`define OMC_WAKE_CFG_ADDR 12'h008
`define OMC_SLEEP_CFG_ADDR 12'h00c
`define OMC_SCRATCH_ADDR 12'h010
`define OMC_STATUS_ADDR 12'h014
// ==========================================
// Control register fields
`define OMC_CTRL_ACTIVE_BIT 0
`define OMC_CTRL_HIB_EN_BIT 1
`define OMC_CTRL_FUNC_LSB 2
`define OMC_CTRL_FUNC_MSB 3
`define OMC_CTRL_AWS_LSB 4
`define OMC_CTRL_AWS_MSB 7
// ==========================================
// Reset values and the trigger function code
`define OMC_CTRL_RST 32'h00000000
`define OMC_AUTO_SLEEP_RST 32'h00000000
`define OMC_RATE_CFG_RST 32'h00000000
`define OMC_FUNC_TRIG 2'h1
// ==========================================
// Timing (ns and cycles at 4 ns)
`define OMC_CLK_PERIOD_NS 4
`define OMC_BOOT1_NS 1000000
`define OMC_BOOT2_NS 1000000
`define OMC_MOT_HIB_NS 1000000
`define OMC_BOOT1_CYC (`OMC_BOOT1_NS / `OMC_CLK_PERIOD_NS)
`define OMC_BOOT2_CYC (`OMC_BOOT2_NS / `OMC_CLK_PERIOD_NS)
`define OMC_MOT_HIB_CYC ((`OMC_MOT_HIB_NS + `OMC_CLK_PERIOD_NS - 1) / `OMC_CLK_PERIOD_NS)
`define OMC_AUTO_TICK_CYC 250
`endif

// file: hdl/omc_edge_det.v
`timescale 1ns/1ps
// ==========================================
// Edge detector on a synchronous input
module omc_edge_det (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_level,
  output wire o_rise,
  output wire o_fall
);
  reg prev_q;
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_level;
    end
  end
  assign o_rise = i_level & ~prev_q;
  assign o_fall = ~i_level & prev_q;
endmodule

// file: bench/omc_operating_mode_properties.sv
`timescale 1ns/1ps
// ==========================================
// Mode checker on the block ports
module omc_operating_mode_properties (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_boot_strap_select,
  input wire i_wake_pin,
  input wire i_motion_detect_pin,
  input wire i_trigger_pin,
  input wire i_meas_done,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  input wire o_meas_start,
  input wire o_sensor_power,
  input wire o_bus_available,
  input wire [2:0] o_mode
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_boot_end;
    o_mode == 3'h1 ##1 o_mode != 3'h1;
  endsequence
  sequence s_trig_edge;
    o_mode == 3'h5 ##0 $rose(i_trigger_pin);
  endsequence
  a_hib_quiet: assert property (o_mode == 3'h0 |-> !o_sensor_power && !o_bus_available)
    else $error("hibernate outputs active");
  a_hib_refuse: assert property (o_mode == 3'h0 && i_psel && i_penable |-> o_pslverr && o_prdata == 32'h0)
    else $error("hibernate access not refused");
  a_wake_edge: assert property (o_mode == 3'h0 && !i_boot_strap_select && $changed(i_wake_pin) |-> ##[1:4] o_mode == 3'h1)
    else $error("wake pin edge ignored");
  a_boot_nobus: assert property (o_mode == 3'h1 |-> !o_bus_available)
    else $error("bus open during boot");
  a_motion_wake: assert property (o_mode == 3'h0 && i_boot_strap_select && i_motion_detect_pin |-> ##[1:4] o_mode == 3'h1)
    else $error("motion pin high ignored");
  a_boot_exit: assert property (s_boot_end |-> (o_mode == 3'h2 || o_mode == 3'h3))
    else $error("boot left to wrong mode");
  a_stby_state: assert property (o_mode == 3'h2 |-> o_bus_available && !o_sensor_power)
    else $error("standby outputs wrong");
  a_active_bus: assert property (o_mode inside {3'h3, 3'h4, 3'h5, 3'h6} |-> o_bus_available)
    else $error("bus closed in active");
  a_trig_start: assert property (s_trig_edge |-> ##[1:4] o_meas_start)
    else $error("trigger edge gave no start");
  a_start_pulse: assert property (o_meas_start |=> !o_meas_start)
    else $error("start longer than one cycle");
  a_trig_return: assert property (o_mode == 3'h6 && i_meas_done |-> ##[1:3] o_mode == 3'h5)
    else $error("no return to trigger wait");
endmodule

// file: bench/omc_meas_model.sv
`timescale 1ns/1ps
// ==========================================
// Measurement unit: one done per start, prompt or slow
module omc_meas_model (
  input wire i_sys_clk,
  input wire i_arst_n,
  input wire i_slow,
  input wire i_meas_start,
  output logic o_meas_done
);
  logic [3:0] cnt_q;
  // Slow answers keep the block waiting in the measuring state
  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 4'h0;
      o_meas_done <= 1'b0;
    end else begin
      o_meas_done <= cnt_q == 4'h1;
      if (i_meas_start) cnt_q <= i_slow ? 4'h9 : 4'h2;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// file: bench/omc_operating_mode_tb.sv
`timescale 1ns/1ps
`include "omc_regs.vh"
module omc_operating_mode_tb;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} omc_row_t;
  logic clk, arst_n, psel, penable, pwrite, strap, wake, mot, trig, wev, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, r;
  wire [31:0] prdata;
  wire pready, pslverr, done, start, spwr, bav, mden;
  wire [2:0] mode;
  wire [7:0] rate;
  logic er;
  int n_mismatch, samples_checked, i, n;
  omc_row_t rows [0:10];
  omc_operating_mode #(.BOOT1_CYC(8), .BOOT2_CYC(8), .MOT_HIB_CYC(8), .TICK_CYC(2))
    omc_operating_mode_inst (.i_sys_clk(clk), .i_arst_n(arst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_boot_strap_select(strap),
    .i_wake_pin(wake), .i_motion_detect_pin(mot), .i_trigger_pin(trig), .i_wake_event(wev),
    .i_meas_done(done), .o_meas_start(start), .o_sensor_power(spwr), .o_bus_available(bav),
    .o_motion_detect_en(mden), .o_mode(mode), .o_rate_setting(rate));
  omc_meas_model omc_meas_model_inst (.i_sys_clk(clk), .i_arst_n(arst_n), .i_slow(slow),
    .i_meas_start(start), .o_meas_done(done));
  // ==========================================
  // Shared tasks
  task end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until pready is sampled high; no latency assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) n_mismatch++;
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, r);
  endtask
  task wait_mode(input logic [2:0] m, input int lim);
    int k;
    k = 0;
    while (mode !== m && k < lim) begin @(posedge clk); k++; end
    chk("mode", {29'h0, m}, {29'h0, mode});
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end
  // ==========================================
  // Main sequence
  initial begin
    arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    strap = 0; wake = 0; mot = 0; trig = 0; wev = 0; slow = 0;
    rows = '{'{1'b0, `OMC_CTRL_ADDR, 32'h0, `OMC_CTRL_RST},
      '{1'b0, `OMC_AUTO_SLEEP_ADDR, 32'h0, `OMC_AUTO_SLEEP_RST},
      '{1'b0, `OMC_WAKE_CFG_ADDR, 32'h0, `OMC_RATE_CFG_RST},
      '{1'b0, `OMC_SLEEP_CFG_ADDR, 32'h0, `OMC_RATE_CFG_RST},
      '{1'b0, `OMC_STATUS_ADDR, 32'h0, 32'h2}, '{1'b1, `OMC_SCRATCH_ADDR, 32'hc3c35a5a, 32'h0},
      '{1'b0, `OMC_SCRATCH_ADDR, 32'h0, 32'hc3c35a5a}, '{1'b1, `OMC_STATUS_ADDR, 32'hffffffff, 32'h0},
      '{1'b0, `OMC_STATUS_ADDR, 32'h0, 32'h2}, '{1'b1, 12'h040, 32'hffffffff, 32'h0},
      '{1'b0, 12'h040, 32'h0, 32'h0}};
    repeat (4) @(posedge clk);
    chk("reset mode", 32'h1, {29'h0, mode});
    arst_n <= 1'b1;
    n = 0;
    while (bav !== 1'b1 && n < 100) begin @(posedge clk); n++; end
    chk("boot length", 32'h1, {31'h0, n >= 8 && n <= 11});
    $display("test reset done");
    for (i = 0; i <= 10; i++) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].e);
    end
    $display("test registers done");
    apb(1'b1, `OMC_CTRL_ADDR, 32'h4);
    wait_mode(3'h5, 20);
    for (i = 0; i < 2; i++) begin
      slow <= i[0];
      trig <= 1'b1;
      wait_mode(3'h6, 10);
      trig <= 1'b0;
      wait_mode(3'h5, 20);
    end
    apb(1'b1, `OMC_CTRL_ADDR, 32'h0);
    wait_mode(3'h2, 20);
    $display("test trigger done");
    apb(1'b1, `OMC_WAKE_CFG_ADDR, 32'h5a);
    apb(1'b1, `OMC_SLEEP_CFG_ADDR, 32'ha5);
    apb(1'b1, `OMC_CTRL_ADDR, 32'h11);
    wait_mode(3'h3, 20);
    chk("motion enable", 32'h0, {31'h0, mden});
    // A zero count must never time out into sleep
    repeat (40) @(posedge clk);
    chk("mode", 32'h3, {29'h0, mode});
    chk("rate", 32'h5a, {24'h0, rate});
    apb(1'b1, `OMC_AUTO_SLEEP_ADDR, 32'h3);
    wait_mode(3'h4, 100);
    repeat (2) @(posedge clk);
    chk("rate", 32'ha5, {24'h0, rate});
    wev <= 1'b1;
    wait_mode(3'h3, 10);
    repeat (2) @(posedge clk);
    chk("rate", 32'h5a, {24'h0, rate});
    wev <= 1'b0;
    apb(1'b1, `OMC_CTRL_ADDR, 32'h0);
    wait_mode(3'h2, 20);
    rd(`OMC_SCRATCH_ADDR, 32'hc3c35a5a);
    $display("test auto sleep done");
    apb(1'b1, `OMC_CTRL_ADDR, 32'h2);
    wait_mode(3'h0, 20);
    apb(1'b0, `OMC_SCRATCH_ADDR, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    wake <= 1'b1;
    wait_mode(3'h1, 10);
    wait_mode(3'h2, 40);
    rd(`OMC_SCRATCH_ADDR, 32'h0);
    apb(1'b1, `OMC_CTRL_ADDR, 32'h2);
    wait_mode(3'h0, 20);
    wake <= 1'b0;
    wait_mode(3'h1, 10);
    wait_mode(3'h2, 40);
    $display("test hibernate done");
    strap <= 1'b1;
    mot <= 1'b1;
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    wait_mode(3'h3, 40);
    chk("motion enable", 32'h1, {31'h0, mden});
    rd(`OMC_CTRL_ADDR, 32'h1);
    rd(`OMC_AUTO_SLEEP_ADDR, `OMC_AUTO_SLEEP_RST);
    apb(1'b1, `OMC_CTRL_ADDR, 32'h1);
    chk("mode", 32'h3, {29'h0, mode});
    mot <= 1'b0;
    wait_mode(3'h2, 40);
    wait_mode(3'h0, 40);
    repeat (20) @(posedge clk);
    chk("mode", 32'h0, {29'h0, mode});
    mot <= 1'b1;
    wait_mode(3'h1, 10);
    wait_mode(3'h3, 40);
    $display("test motion done");
    end_of_test;
  end
endmodule
bind omc_operating_mode omc_operating_mode_properties omc_props_inst (.i_sys_clk(i_sys_clk),
  .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_boot_strap_select(i_boot_strap_select), .i_wake_pin(i_wake_pin),
  .i_motion_detect_pin(i_motion_detect_pin), .i_trigger_pin(i_trigger_pin),
  .i_meas_done(i_meas_done), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .o_meas_start(o_meas_start), .o_sensor_power(o_sensor_power),
  .o_bus_available(o_bus_available), .o_mode(o_mode));
